// *** rsc_pkg.sv ***
package rsc_pkg;

  // ==========================================================
  // Command encodings
  localparam logic [7:0] CODE_RX_RD = 8'h61;
  localparam logic [7:0] CODE_TX_WR = 8'ha0;
  localparam logic [7:0] CODE_FLUSH_TX = 8'he1;
  localparam logic [7:0] CODE_FLUSH_RX = 8'he2;
  localparam logic [7:0] CODE_REUSE = 8'he3;
  localparam logic [7:0] CODE_WIDTH = 8'h60;
  localparam logic [7:0] CODE_TX_NOACK = 8'hb0;
  localparam logic [7:0] CODE_IDLE = 8'hff;
  localparam logic [2:0] TOP_REG_RD = 3'h0;
  localparam logic [2:0] TOP_REG_WR = 3'h1;
  localparam logic [4:0] TOP_ACK_WR = 5'h15;
  localparam logic [2:0] PIPE_INDEX_MAX = 3'h5;

  // ==========================================================
  // Sizes, status layout, fill values
  localparam int REG_BYTES_DEF = 5;
  localparam int PAY_BYTES_DEF = 32;
  localparam int ACK_DEPTH_DEF = 3;
  localparam int STAT_FLAG_LSB = 4;
  localparam int STAT_PIPE_LSB = 1;
  localparam int STAT_FULL_BIT = 0;
  localparam logic [7:0] BYTE_PAST_END = 8'h00;
  localparam logic [5:0] BYTE_CNT_SAT = 6'h3f;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    CMD_IDLE, CMD_REG_RD, CMD_REG_WR, CMD_RX_RD, CMD_TX_WR, CMD_TX_NOACK,
    CMD_ACK_WR, CMD_FLUSH_TX, CMD_FLUSH_RX, CMD_REUSE, CMD_WIDTH
  } rsc_cmd_t;

  typedef enum logic [1:0] {RD_NONE, RD_REG, RD_PAYLOAD, RD_WIDTH} rsc_rd_kind_t;

  typedef struct packed {
    rsc_rd_kind_t kind;
    logic [4:0] addr;
    logic [5:0] idx;
  } rsc_rd_req_t;

  typedef struct packed {
    logic reg_en;
    logic tx_en;
    logic ack_en;
    logic [4:0] addr;
    logic [2:0] pipe;
    logic [5:0] idx;
    logic [7:0] data;
  } rsc_wr_t;

  typedef struct packed {
    logic tx_commit;
    logic no_ack;
    logic ack_commit;
    logic [2:0] pipe;
    logic rx_pop;
    logic flush_tx;
    logic flush_rx;
  } rsc_act_t;

  typedef struct packed {
    logic [7:0] status;
    logic en_width;
    logic en_ack;
    logic en_noack;
  } rsc_snap_t;

  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] data;
  } rsc_byte_t;

  // Command byte to command, option_enable_reg gating applied
  function automatic rsc_cmd_t rsc_decode(input logic [7:0] b,
                                          input rsc_snap_t s);
    rsc_cmd_t c;
    c = CMD_IDLE;
    if (b[7:5] == TOP_REG_RD) begin
      c = CMD_REG_RD;
    end else if (b[7:5] == TOP_REG_WR) begin
      c = CMD_REG_WR;
    end else if (b[7:3] == TOP_ACK_WR) begin
      if (s.en_ack && b[2:0] <= PIPE_INDEX_MAX) c = CMD_ACK_WR;
    end else if (b == CODE_RX_RD) begin
      c = CMD_RX_RD;
    end else if (b == CODE_TX_WR) begin
      c = CMD_TX_WR;
    end else if (b == CODE_TX_NOACK) begin
      if (s.en_noack) c = CMD_TX_NOACK;
    end else if (b == CODE_FLUSH_TX) begin
      c = CMD_FLUSH_TX;
    end else if (b == CODE_FLUSH_RX) begin
      c = CMD_FLUSH_RX;
    end else if (b == CODE_REUSE) begin
      c = CMD_REUSE;
    end else if (b == CODE_WIDTH) begin
      if (s.en_width) c = CMD_WIDTH;
    end
    return c;
  endfunction

endpackage

// *** rsc_decoder.sv ***
`timescale 1ns/1ps
// Behaviour
// - 000+address reads the register, returning up to five bytes, low byte first.
// - 001+address writes the register with up to five bytes, low byte first.
// - Register writes act only in power-down or standby; host obeys likewise.
// - Payload read shifts out up to 32 bytes, starting at byte zero.
// - A payload read out is removed from the receive queue.
// - Payload write takes up to 32 bytes from byte zero as new payload.
// - Transmit flush discards all transmit payloads; no data bytes.
// - Receive flush discards all received payloads; no data bytes.
// - Reuse command keeps resending last payload until payload write or transmit flush.
// - Width query returns one byte: width of head received payload.
// - 10101+pipe loads acknowledgement payload; pipes zero to five, from byte zero.
// - At most three pending acknowledgement payloads; same pipe keeps FIFO order.
// - No-acknowledge payload write takes up to 32 bytes, acknowledge off once.
// - Idle command does nothing; only status byte returns.
// - Width query, ack payload, no-ack write need their option_enable_reg enables.
// - Multi-byte values go low byte first, each byte MSB first.
// - Short register write leaves the unwritten upper bytes unchanged.
// - Status byte shifts out while the command byte shifts in.
// - Pipe field of status updates on interrupt falling edge.
// - Command byte goes MSB first, ahead of the data bytes.
module rsc_decoder
  import rsc_pkg::*;
#(
  parameter int REG_BYTES = REG_BYTES_DEF,
  parameter int PAY_BYTES = PAY_BYTES_DEF,
  parameter int ACK_DEPTH = ACK_DEPTH_DEF
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial link, clocked by the host
  input wire logic sck_i,
  input wire logic csn_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Read data lookup, answered combinationally
  output rsc_rd_req_t rd_req_o,
  input wire logic [7:0] rd_byte_i,
  // Status sources
  input wire logic [2:0] irq_flags_i,
  input wire logic tx_full_i,
  input wire logic [2:0] rx_pipe_i,
  input wire logic irq_n_i,
  // Mode, option_enable_reg enables and pending acknowledgement count
  input wire logic standby_i,
  input wire logic en_width_i,
  input wire logic en_ack_i,
  input wire logic en_noack_i,
  input wire logic [1:0] ack_pending_i,
  // Actions toward register map and queues
  output rsc_wr_t wr_o,
  output rsc_act_t act_o,
  output logic reuse_o
);

  // ==========================================================
  // Parameter check
  generate
    if (REG_BYTES < 1 || REG_BYTES > 32 || PAY_BYTES < 1 ||
        PAY_BYTES > 62 || ACK_DEPTH < 1 || ACK_DEPTH > 3) begin : g_bad
      $error("rsc_decoder: unsupported parameter value");
    end
  endgenerate

  localparam logic [5:0] REG_LIM = 6'(REG_BYTES);
  localparam logic [5:0] PAY_LIM = 6'(PAY_BYTES);
  localparam logic [1:0] ACK_LIM = 2'(ACK_DEPTH);

  // ==========================================================
  // Frame-stable snapshot, written only between frames
  rsc_snap_t snap_reg;
  rsc_snap_t snap_next;
  logic [2:0] pipe_reg;
  logic irq_q_reg;
  logic csn_s1_reg;
  logic csn_s2_reg;
  logic csn_s3_reg;
  logic csn_s4_reg;

  always_comb begin
    snap_next = '0;
    snap_next.status[STAT_FLAG_LSB +: 3] = irq_flags_i;
    snap_next.status[STAT_PIPE_LSB +: 3] = pipe_reg;
    snap_next.status[STAT_FULL_BIT] = tx_full_i;
    snap_next.en_width = en_width_i;
    snap_next.en_ack = en_ack_i;
    snap_next.en_noack = en_noack_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q_reg <= 1'b1;
      pipe_reg <= '0;
    end else begin
      irq_q_reg <= irq_n_i;
      if (irq_q_reg && !irq_n_i) pipe_reg <= rx_pipe_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      snap_reg <= '0;
    end else if (csn_s2_reg) begin
      snap_reg <= snap_next;
    end
  end

  // ==========================================================
  // Link domain: shifting and byte framing
  logic lk_rst_n;
  logic [2:0] bit_cnt_reg;
  logic [5:0] byte_cnt_reg;
  logic [6:0] sr_reg;
  logic [7:0] byte_in;
  rsc_cmd_t lk_cmd_reg;
  logic [4:0] lk_addr_reg;
  rsc_byte_t lk_byte_reg;
  logic lk_tog_reg;

  assign lk_rst_n = nrst_i & ~csn_n_i;
  assign byte_in = {sr_reg, mosi_i};

  always_ff @(posedge sck_i or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      sr_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      sr_reg <= byte_in[6:0];
      if (bit_cnt_reg == BIT_LAST && byte_cnt_reg != BYTE_CNT_SAT) begin
        byte_cnt_reg <= byte_cnt_reg + 6'h1;
      end
    end
  end

  always_ff @(posedge sck_i or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_cmd_reg <= CMD_IDLE;
      lk_addr_reg <= '0;
    end else if (bit_cnt_reg == BIT_LAST && byte_cnt_reg == '0) begin
      lk_cmd_reg <= rsc_decode(byte_in, snap_reg);
      lk_addr_reg <= byte_in[4:0];
    end
  end

  always_ff @(posedge sck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lk_byte_reg <= '0;
      lk_tog_reg <= 1'b0;
    end else if (bit_cnt_reg == BIT_LAST) begin
      lk_byte_reg <= '{idx: byte_cnt_reg, data: byte_in};
      lk_tog_reg <= ~lk_tog_reg;
    end
  end

  // ==========================================================
  // Link domain: read lookup and serial output
  logic [5:0] rd_idx;
  logic [7:0] tx_byte;

  assign rd_idx = byte_cnt_reg - 6'h1;

  always_comb begin
    rd_req_o = '0;
    rd_req_o.addr = lk_addr_reg;
    rd_req_o.idx = rd_idx;
    if (byte_cnt_reg != '0) begin
      unique case (lk_cmd_reg)
        CMD_REG_RD: if (rd_idx < REG_LIM) rd_req_o.kind = RD_REG;
        CMD_RX_RD: if (rd_idx < PAY_LIM) rd_req_o.kind = RD_PAYLOAD;
        CMD_WIDTH: if (rd_idx == '0) rd_req_o.kind = RD_WIDTH;
        default: rd_req_o.kind = RD_NONE;
      endcase
    end
  end

  always_comb begin
    if (byte_cnt_reg == '0) begin
      tx_byte = snap_reg.status;
    end else if (rd_req_o.kind != RD_NONE) begin
      tx_byte = rd_byte_i;
    end else begin
      tx_byte = BYTE_PAST_END;
    end
  end

  assign miso_o = tx_byte[~bit_cnt_reg];
  assign miso_oe_o = ~csn_n_i;

  // ==========================================================
  // Crossing into the system domain
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_q_reg;
  logic ev;
  logic frame_start;
  logic frame_end;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csn_s1_reg <= 1'b1;
      csn_s2_reg <= 1'b1;
      csn_s3_reg <= 1'b1;
      csn_s4_reg <= 1'b1;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_q_reg <= 1'b0;
    end else begin
      csn_s1_reg <= csn_n_i;
      csn_s2_reg <= csn_s1_reg;
      csn_s3_reg <= csn_s2_reg;
      csn_s4_reg <= csn_s3_reg;
      tog_s1_reg <= lk_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_q_reg <= tog_s2_reg;
    end
  end

  assign ev = tog_s2_reg ^ tog_q_reg;
  assign frame_start = csn_s3_reg & ~csn_s2_reg;
  assign frame_end = csn_s3_reg & ~csn_s4_reg;

  // ==========================================================
  // System domain: command tracking
  rsc_cmd_t cmd_reg;
  rsc_cmd_t ev_cmd;
  logic data_seen_reg;
  logic ack_ok_reg;
  logic [2:0] ack_pipe_reg;
  logic [5:0] di;

  assign ev_cmd = rsc_decode(lk_byte_reg.data, snap_reg);
  assign di = lk_byte_reg.idx - 6'h1;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_reg <= CMD_IDLE;
      data_seen_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      ack_pipe_reg <= '0;
    end else if (frame_start) begin
      cmd_reg <= CMD_IDLE;
      data_seen_reg <= 1'b0;
    end else if (ev && lk_byte_reg.idx == '0) begin
      cmd_reg <= ev_cmd;
      ack_ok_reg <= ack_pending_i < ACK_LIM;
      ack_pipe_reg <= lk_byte_reg.data[2:0];
    end else if (ev) begin
      data_seen_reg <= 1'b1;
    end
  end

  // ==========================================================
  // System domain: write strobes
  rsc_wr_t wr_next;
  logic [4:0] addr_reg;

  always_comb begin
    wr_next = '0;
    wr_next.addr = addr_reg;
    wr_next.pipe = ack_pipe_reg;
    wr_next.idx = di;
    wr_next.data = lk_byte_reg.data;
    if (ev && lk_byte_reg.idx != '0) begin
      unique case (cmd_reg)
        CMD_REG_WR: wr_next.reg_en = standby_i && di < REG_LIM;
        CMD_TX_WR, CMD_TX_NOACK: wr_next.tx_en = di < PAY_LIM;
        CMD_ACK_WR: wr_next.ack_en = ack_ok_reg && di < PAY_LIM;
        default: wr_next.reg_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_reg <= '0;
    end else if (ev && lk_byte_reg.idx == '0) begin
      addr_reg <= lk_byte_reg.data[4:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_o <= '0;
    end else begin
      wr_o <= wr_next;
    end
  end

  // ==========================================================
  // System domain: commits, flushes and reuse
  rsc_act_t act_next;
  logic is_tx;

  assign is_tx = cmd_reg == CMD_TX_WR || cmd_reg == CMD_TX_NOACK;

  always_comb begin
    act_next = '0;
    if (frame_end && data_seen_reg) begin
      if (cmd_reg == CMD_ACK_WR && ack_ok_reg) act_next.pipe = ack_pipe_reg;
      act_next.tx_commit = is_tx;
      act_next.no_ack = cmd_reg == CMD_TX_NOACK;
      act_next.ack_commit = cmd_reg == CMD_ACK_WR && ack_ok_reg;
      act_next.rx_pop = cmd_reg == CMD_RX_RD;
    end
    if (ev && lk_byte_reg.idx == '0) begin
      act_next.flush_tx = ev_cmd == CMD_FLUSH_TX;
      act_next.flush_rx = ev_cmd == CMD_FLUSH_RX;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_o <= '0;
    end else begin
      act_o <= act_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reuse_o <= 1'b0;
    end else if (ev && lk_byte_reg.idx == '0 && ev_cmd == CMD_REUSE) begin
      reuse_o <= 1'b1;
    end else if (act_next.tx_commit || act_next.flush_tx) begin
      reuse_o <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_reg_wr_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_o.reg_en |-> $past(standby_i) && wr_o.idx < REG_LIM)
    else $error("register write outside standby or past end");

  a_pay_idx_limit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_o.tx_en || wr_o.ack_en) |-> wr_o.idx < PAY_LIM)
    else $error("payload byte index beyond limit");

  a_reuse_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (act_o.tx_commit || act_o.flush_tx) |-> !reuse_o)
    else $error("reuse still set after payload write or flush");

  a_reuse_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ev && lk_byte_reg.idx == '0 && ev_cmd == CMD_REUSE) |=> reuse_o)
    else $error("reuse not set by command");

  a_ack_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
    act_o.ack_commit |-> act_o.pipe <= PIPE_INDEX_MAX && snap_reg.en_ack)
    else $error("acknowledge payload committed illegally");

  a_noack_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (act_o.tx_commit && act_o.no_ack) |-> snap_reg.en_noack)
    else $error("no-ack payload without enable");

  a_pipe_update: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (irq_q_reg && !irq_n_i) |=> pipe_reg == $past(rx_pipe_i))
    else $error("pipe field missed interrupt edge");

  a_pipe_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(irq_q_reg && !irq_n_i) |=> $stable(pipe_reg))
    else $error("pipe field changed without interrupt edge");

  a_pop_after_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    act_o.rx_pop |-> $past(cmd_reg) == CMD_RX_RD && $past(csn_s3_reg))
    else $error("receive pop without payload read");

  a_status_first: assert property (@(posedge sck_i) disable iff (!lk_rst_n)
    byte_cnt_reg == '0 |-> miso_o == snap_reg.status[~bit_cnt_reg])
    else $error("status byte not on serial output");

endmodule

// *** rsc_host_model.sv ***
`timescale 1ns/1ps
module rsc_host_model (
  // Serial link toward the device
  output logic sck_o,
  output logic csn_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  logic [7:0] tx_buf [0:39];
  logic [7:0] rx_buf [0:39];

  // ==========================================================
  // Idle levels: clock still, data line never stale
  initial begin
    sck_o = 1'b0;
    csn_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  always #32 if (csn_n_o) mosi_o = ~mosi_o;

  // ==========================================================
  // One frame: command byte then n data bytes, 64 ns bit period
  task automatic frame(input int n);
    int b;
    int k;
    csn_n_o = 1'b0;
    #40;
    for (b = 0; b <= n; b++) begin
      for (k = 7; k >= 0; k--) begin
        mosi_o = tx_buf[b][k];
        #31;
        rx_buf[b][k] = miso_i;
        #1 sck_o = 1'b1;
        #32 sck_o = 1'b0;
      end
    end
    #32 csn_n_o = 1'b1;
    #100;
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import rsc_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] irq_flags_i = 3'h0;
  logic tx_full_i = 1'b0;
  logic [2:0] rx_pipe_i = 3'h0;
  logic irq_n_i = 1'b1;
  logic standby_i = 1'b0;
  logic en_width_i = 1'b0;
  logic en_ack_i = 1'b0;
  logic en_noack_i = 1'b0;
  logic [1:0] ack_pending_i = 2'h0;
  logic [7:0] rd_byte_i;
  wire sck;
  wire csn_n;
  wire mosi;
  wire miso_w;
  logic miso_o;
  logic miso_oe_o;
  rsc_rd_req_t rd_req_o;
  rsc_wr_t wr_o;
  rsc_act_t act_o;
  logic reuse_o;
  rsc_wr_t wq[$];
  rsc_act_t aq[$];
  int num_errors = 0;
  int tests_run = 0;

  initial forever #5 clk_i = ~clk_i;

  // Released line toggles so nothing stale is read
  assign miso_w = miso_oe_o ? miso_o : clk_i;

  // Register map and queue lookup answered at once
  always_comb begin
    case (rd_req_o.kind)
      RD_REG: rd_byte_i = {rd_req_o.addr, rd_req_o.idx[2:0]};
      RD_PAYLOAD: rd_byte_i = {2'h2, rd_req_o.idx};
      RD_WIDTH: rd_byte_i = 8'h1c;
      default: rd_byte_i = 8'h00;
    endcase
  end

  rsc_host_model rsc_host_model_i (
    .sck_o(sck), .csn_n_o(csn_n), .mosi_o(mosi), .miso_i(miso_w)
  );

  rsc_decoder rsc_decoder_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck), .csn_n_i(csn_n),
    .mosi_i(mosi), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .rd_req_o(rd_req_o), .rd_byte_i(rd_byte_i),
    .irq_flags_i(irq_flags_i), .tx_full_i(tx_full_i),
    .rx_pipe_i(rx_pipe_i), .irq_n_i(irq_n_i), .standby_i(standby_i),
    .en_width_i(en_width_i), .en_ack_i(en_ack_i),
    .en_noack_i(en_noack_i), .ack_pending_i(ack_pending_i),
    .wr_o(wr_o), .act_o(act_o), .reuse_o(reuse_o)
  );

  // ==========================================================
  // Pulse logging
  always_ff @(posedge clk_i) begin
    if (wr_o.reg_en || wr_o.tx_en || wr_o.ack_en) wq.push_back(wr_o);
    if (|act_o) aq.push_back(act_o);
  end

  // ==========================================================
  // Shared tasks
  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [7:0] cmd, input int n);
    int i;
    rsc_host_model_i.tx_buf[0] = cmd;
    for (i = 1; i <= n; i++) rsc_host_model_i.tx_buf[i] = 8'hc0 ^ 8'(i - 1);
    wq.delete();
    aq.delete();
    rsc_host_model_i.frame(n);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic chk_wr(input int n, input int kind, input logic [4:0] a);
    int i;
    chk(wq.size(), n);
    for (i = 0; i < wq.size(); i++) begin
      chk({wq[i].reg_en, wq[i].tx_en, wq[i].ack_en}, 3'h4 >> kind);
      chk(wq[i].idx, i);
      chk(wq[i].data, 8'hc0 ^ i[7:0]);
      if (kind == 0) chk(wq[i].addr, a);
      if (kind == 2) chk(wq[i].pipe, a);
    end
  endtask

  task automatic chk_act(input logic [8:0] e);
    chk(aq.size(), (e == 9'h000) ? 0 : 1);
    if (aq.size() > 0) chk(aq[0], e);
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #500000;
    num_errors++;
    close_out;
  end

  // ==========================================================
  // Test sequence
  initial begin
    int i;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    irq_flags_i <= 3'h5;
    tx_full_i <= 1'b1;
    rx_pipe_i <= 3'h3;
    @(posedge clk_i);
    irq_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rx_pipe_i <= 3'h6;
    run(CODE_IDLE, 0);
    chk(rsc_host_model_i.rx_buf[0], 8'h57);
    chk(miso_oe_o, 1'b0);
    chk_wr(0, 0, 5'h00);
    chk_act(9'h000);
    run(8'hf0, 2);
    chk(rsc_host_model_i.rx_buf[0], 8'h57);
    chk_wr(0, 0, 5'h00);
    chk_act(9'h000);
    run(8'h03, 6);
    for (i = 0; i < 5; i++) begin
      chk(rsc_host_model_i.rx_buf[i + 1], 8'h18 + i[7:0]);
    end
    chk(rsc_host_model_i.rx_buf[6], BYTE_PAST_END);
    run(8'h22, 2);
    chk_wr(0, 0, 5'h02);
    @(posedge clk_i);
    standby_i <= 1'b1;
    run(8'h22, 2);
    chk_wr(2, 0, 5'h02);
    run(8'h3f, 6);
    chk_wr(5, 0, 5'h1f);
    run(CODE_REUSE, 0);
    chk(reuse_o, 1'b1);
    run(CODE_TX_WR, 3);
    chk_wr(3, 1, 5'h00);
    chk_act(9'h100);
    chk(reuse_o, 1'b0);
    run(CODE_REUSE, 0);
    run(CODE_FLUSH_TX, 0);
    chk_act(9'h002);
    chk(reuse_o, 1'b0);
    run(CODE_FLUSH_RX, 0);
    chk_act(9'h001);
    run(CODE_RX_RD, 3);
    for (i = 0; i < 3; i++) begin
      chk(rsc_host_model_i.rx_buf[i + 1], 8'h80 + i[7:0]);
    end
    chk_act(9'h004);
    run(CODE_WIDTH, 1);
    chk(rsc_host_model_i.rx_buf[1], BYTE_PAST_END);
    run(CODE_TX_NOACK, 2);
    chk_wr(0, 1, 5'h00);
    chk_act(9'h000);
    @(posedge clk_i);
    en_width_i <= 1'b1;
    en_ack_i <= 1'b1;
    en_noack_i <= 1'b1;
    run(CODE_WIDTH, 1);
    chk(rsc_host_model_i.rx_buf[1], 8'h1c);
    run(CODE_TX_NOACK, 2);
    chk_wr(2, 1, 5'h00);
    chk_act(9'h180);
    run(8'ha9, 2);
    chk_wr(2, 2, 5'h01);
    chk_act(9'h048);
    run(8'hae, 2);
    chk_wr(0, 2, 5'h06);
    chk_act(9'h000);
    @(posedge clk_i);
    ack_pending_i <= 2'h3;
    run(8'hac, 1);
    chk_wr(0, 2, 5'h04);
    chk_act(9'h000);
    close_out;
  end
endmodule
